// >>> hdl/pwmtb_map.svh
// register offsets, field positions and timing constants of the pwm trigger/blanking block
// assumes a wishbone slave with byte addresses and 32-bit data
`ifndef PWMTB_MAP_SVH
`define PWMTB_MAP_SVH
`define PWMTB_IRQ_DISABLE_OFF   12'h014
`define PWMTB_IRQ_ENABLE_OFF    12'h010
`define PWMTB_IRQ_MASK_OFF      12'h018
`define PWMTB_PROTECT_OFF       12'h0E4
`define PWMTB_IRQ_STATUS_OFF    12'h020
`define PWMTB_IRQ_SMASK_OFF     12'h024
`define PWMTB_PRESCALE_OFF      12'h028
`define PWMTB_ETRG1_OFF         12'h06C
`define PWMTB_ETRG2_OFF         12'h07C
`define PWMTB_BLANK1_OFF        12'h070
`define PWMTB_BLANK2_OFF        12'h080
`define PWMTB_PERIOD_UPD_OFF    12'h210
`define PWMTB_PERIOD_STRIDE     12'h020
`define PWMTB_PERIOD_ACT_OFF    12'h20C
`define PWMTB_CH_COUNT          4
`define PWMTB_FAULT_DIS_POS     16
`define PWMTB_IRQ_FIELDS        32'h000F000F
`define PWMTB_PERIOD_WIDTH      16
`define PWMTB_PERIOD_RESET      16'hFFFF
`define PWMTB_TRGSEL_POS        0
`define PWMTB_TRIGGER_FILTER_ENABLE_POS       1
`define PWMTB_LFEN_POS          16
`define PWMTB_LREN_POS          17
`define PWMTB_HFEN_POS          18
`define PWMTB_HREN_POS          19
`define PWMTB_DELAY_WIDTH       7
`define PWMTB_FILTER_CYCLES     3
`define PWMTB_PRESCALE_MAX      4'hA
`define PWMTB_PROT_SW1_POS      1
`define PWMTB_PROT_SW3_POS      3
`define PWMTB_PROT_HW1_POS      9
`define PWMTB_PROT_HW3_POS      11
`endif

// >>> hdl/pwmtb_pkg.sv
// types shared by the pwm trigger/blanking block
// assumes pwmtb_map.svh for numeric constants
package pwmtb_pkg;
  typedef logic [15:0] pwmtb_period_t;
  typedef logic [6:0]  pwmtb_delay_t;
  typedef enum logic [1:0] {PWMTB_IDLE, PWMTB_ACK} pwmtb_bus_state_t;
endpackage

// >>> hdl/pwmtb_trig_if.sv
// carrier between the top and one trigger conditioning channel
// assumes one clock domain
`timescale 1ns/100ps
interface pwmtb_trig_if;
  logic                  raw_trigger;
  logic                  source_select;
  logic                  filter_enable;
  logic [3:0]            blank_enables;
  pwmtb_pkg::pwmtb_delay_t blank_delay;
  logic                  high_out;
  logic                  low_out;
  logic                  comparator;
  logic                  trigger_event;
  logic                  blanking;
  modport top (output raw_trigger, source_select, filter_enable, blank_enables, blank_delay,
               high_out, low_out, comparator, input trigger_event, blanking);
  modport chan (input raw_trigger, source_select, filter_enable, blank_enables, blank_delay,
                high_out, low_out, comparator, output trigger_event, blanking);
endinterface

// >>> hdl/pwmtb_trig_chan.sv
// one external trigger channel: select, filter, leading-edge blanking, edge detect
// assumes raw_trigger already passed a two-flop synchroniser
`timescale 1ns/100ps
`include "pwmtb_map.svh"
module pwmtb_trig_chan (
  input wire logic    clk,
  input wire logic    rst_n,
  pwmtb_trig_if.chan  tif
);
  logic       selected;
  logic [1:0] filt_cnt;
  logic       filtered;
  logic       used;
  logic       used_d;
  logic       high_d;
  logic       low_d;
  logic       blank_start;
  logic       blank_armed;
  pwmtb_pkg::pwmtb_delay_t blank_cnt;

  assign selected = tif.source_select ? tif.comparator : tif.raw_trigger;

  // level must stay stable for a few cycles before it is passed on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt <= 2'h0;
      filtered <= 1'b0;
    end else if (selected == filtered) begin
      filt_cnt <= 2'h0;
    end else if (filt_cnt == 2'(`PWMTB_FILTER_CYCLES - 1)) begin
      filt_cnt <= 2'h0;
      filtered <= selected;
    end else begin
      filt_cnt <= filt_cnt + 2'h1;
    end
  end

  assign used = tif.filter_enable ? filtered : selected;

  // blank_enables: {high rise, high fall, low rise, low fall}
  assign blank_start = (tif.blank_enables[3] & tif.high_out & ~high_d)
                     | (tif.blank_enables[2] & ~tif.high_out & high_d)
                     | (tif.blank_enables[1] & tif.low_out & ~low_d)
                     | (tif.blank_enables[0] & ~tif.low_out & low_d);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_d <= 1'b0;
      low_d  <= 1'b0;
      used_d <= 1'b0;
    end else begin
      high_d <= tif.high_out;
      low_d  <= tif.low_out;
      used_d <= used;
    end
  end

  // the edge cycle is the first blanked cycle, so blanking lasts blank_delay cycles
  // and a delay of zero blanks nothing
  assign blank_armed = blank_start & (tif.blank_delay != 7'h00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_cnt <= 7'h00;
    end else if (blank_armed) begin
      blank_cnt <= tif.blank_delay - 7'h01;
    end else if (blank_cnt != 7'h00) begin
      blank_cnt <= blank_cnt - 7'h01;
    end
  end

  assign tif.blanking      = blank_armed | (blank_cnt != 7'h00);
  assign tif.trigger_event = used & ~used_d & ~tif.blanking;
endmodule

// >>> hdl/pwmtb_top.sv
// pwm external trigger, blanking, interrupt-disable and period update registers
// assumes a classic wishbone master on clk; trigger pins are asynchronous
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "pwmtb_map.svh"
module pwmtb_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  ext_trigger_input,
  input  wire logic        comparator_out,
  input  wire logic        hw_protect_group_one,
  input  wire logic        hw_protect_group_three,
  input  wire logic [3:0]  counter_event,
  input  wire logic [3:0]  fault_event,
  output logic      [1:0]  high_side_output,
  output logic      [1:0]  low_side_output,
  output logic      [1:0]  trigger_event,
  output logic             irq
);
  localparam int CH = `PWMTB_CH_COUNT;

  logic [1:0]  trig_s1;
  logic [1:0]  trig_s2;
  logic [1:0]  hwp_s1;
  logic [1:0]  hwp_s2;
  logic        sw_protect_group_one;
  logic        sw_protect_group_three;
  logic [31:0] irq_mask;
  logic [31:0] irq_status;
  logic [31:0] irq_event;
  logic [3:0]  prescaler_select;
  logic [1:0]  trigger_source_select;
  logic [1:0]  trigger_filter_enable;
  logic [3:0]  blank_en [2];
  pwmtb_pkg::pwmtb_delay_t blanking_delay [2];
  pwmtb_pkg::pwmtb_period_t period_update_value [CH];
  pwmtb_pkg::pwmtb_period_t active_period_value [CH];
  logic [CH-1:0] update_pending;
  pwmtb_pkg::pwmtb_period_t counter [CH];
  logic [CH-1:0] period_end;
  logic [9:0]  prescale_cnt;
  logic        prescale_tick;
  logic [9:0]  prescale_mask;
  logic        wr;
  logic        rd;
  logic [31:0] wdata;
  logic [31:0] next_dat;
  logic [1:0]  trig_evt;
  pwmtb_pkg::pwmtb_bus_state_t bus_state;

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // period register channel index, or CH when not a period address
  function automatic logic [2:0] period_index(input logic [11:0] adr);
    period_index = 3'(CH);
    for (int i = 0; i < CH; i++) begin
      if (adr == 12'(`PWMTB_PERIOD_UPD_OFF + i * `PWMTB_PERIOD_STRIDE)) begin
        period_index = 3'(i);
      end
    end
  endfunction

  function automatic logic is_active_period(input logic [11:0] adr, input int i);
    is_active_period = adr == 12'(`PWMTB_PERIOD_ACT_OFF + i * `PWMTB_PERIOD_STRIDE);
  endfunction

  // a protection group allows writes only while its software and hardware bits are clear
  function automatic logic prot_clear(input logic sw, input logic hw);
    prot_clear = !sw && !hw;
  endfunction

  // wishbone: ack one cycle after strobe, dropped the cycle after
  // writes land on the request edge; while ack stands the state is no longer idle,
  // so the strobe that is still present is not taken a second time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= pwmtb_pkg::PWMTB_IDLE;
    end else begin
      case (bus_state)
        pwmtb_pkg::PWMTB_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            bus_state <= pwmtb_pkg::PWMTB_ACK;
          end
        end
        pwmtb_pkg::PWMTB_ACK: bus_state <= pwmtb_pkg::PWMTB_IDLE;
        default:               bus_state <= pwmtb_pkg::PWMTB_IDLE;
      endcase
    end
  end

  assign wb_ack_o = bus_state == pwmtb_pkg::PWMTB_ACK;
  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && bus_state == pwmtb_pkg::PWMTB_IDLE;
  assign rd       = wb_cyc_i && wb_stb_i && !wb_we_i && bus_state == pwmtb_pkg::PWMTB_IDLE;
  assign wdata    = wb_dat_i & lane_mask(wb_sel_i);

  // pins from outside pass two flops
  // the hardware protection levels come from outside too and are synced the same way
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_s1 <= 2'h0;
      trig_s2 <= 2'h0;
      hwp_s1  <= 2'h0;
      hwp_s2  <= 2'h0;
    end else begin
      trig_s1 <= ext_trigger_input;
      trig_s2 <= trig_s1;
      hwp_s1  <= {hw_protect_group_three, hw_protect_group_one};
      hwp_s2  <= hwp_s1;
    end
  end

  // software protection bits, group 1 and 3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_protect_group_one   <= 1'b0;
      sw_protect_group_three <= 1'b0;
    end else if (wr && wb_adr_i == `PWMTB_PROTECT_OFF && wb_sel_i[0]) begin
      sw_protect_group_one   <= wb_dat_i[`PWMTB_PROT_SW1_POS];
      sw_protect_group_three <= wb_dat_i[`PWMTB_PROT_SW3_POS];
    end
  end

  // channel interrupt enable mask; disable register clears, enable register sets
  // only the four counter and four fault positions are ever stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 32'h00000000;
    end else if (wr && prot_clear(sw_protect_group_one, hwp_s2[0])) begin
      if (wb_adr_i == `PWMTB_IRQ_DISABLE_OFF) begin
        irq_mask <= irq_mask & ~(wdata & `PWMTB_IRQ_FIELDS);
      end else if (wb_adr_i == `PWMTB_IRQ_ENABLE_OFF) begin
        irq_mask <= irq_mask | (wdata & `PWMTB_IRQ_FIELDS);
      end
    end
  end

  // sticky status; set wins over write-one-to-clear
  assign irq_event = {12'h000, fault_event, 12'h000, counter_event};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 32'h00000000;
    end else if (wr && wb_adr_i == `PWMTB_IRQ_STATUS_OFF) begin
      irq_status <= (irq_status & ~wdata) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // registered so the level line cannot glitch while status and mask change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // trigger and blanking configuration, channels 1 and 2 only, and the prescaler select
  // these registers are not write protected and take all byte lanes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_source_select <= 2'h0;
      trigger_filter_enable <= 2'h0;
      blank_en[0]           <= 4'h0;
      blank_en[1]           <= 4'h0;
      blanking_delay[0]     <= 7'h00;
      blanking_delay[1]     <= 7'h00;
      prescaler_select      <= 4'h0;
    end else if (wr) begin
      case (wb_adr_i)
        `PWMTB_ETRG1_OFF: begin
          trigger_source_select[0] <= wb_dat_i[`PWMTB_TRGSEL_POS];
          trigger_filter_enable[0] <= wb_dat_i[`PWMTB_TRIGGER_FILTER_ENABLE_POS];
        end
        `PWMTB_ETRG2_OFF: begin
          trigger_source_select[1] <= wb_dat_i[`PWMTB_TRGSEL_POS];
          trigger_filter_enable[1] <= wb_dat_i[`PWMTB_TRIGGER_FILTER_ENABLE_POS];
        end
        `PWMTB_BLANK1_OFF: begin
          blanking_delay[0] <= wb_dat_i[`PWMTB_DELAY_WIDTH-1:0];
          blank_en[0]       <= wb_dat_i[`PWMTB_HREN_POS:`PWMTB_LFEN_POS];
        end
        `PWMTB_BLANK2_OFF: begin
          blanking_delay[1] <= wb_dat_i[`PWMTB_DELAY_WIDTH-1:0];
          blank_en[1]       <= wb_dat_i[`PWMTB_HREN_POS:`PWMTB_LFEN_POS];
        end
        `PWMTB_PRESCALE_OFF: begin
          if (wb_dat_i[3:0] <= `PWMTB_PRESCALE_MAX) begin
            prescaler_select <= wb_dat_i[3:0];
          end
        end
        default: ;
      endcase
    end
  end

  // prescaler: tick every 2^prescaler_select clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_cnt <= 10'h000;
    end else begin
      prescale_cnt <= prescale_cnt + 10'h001;
    end
  end
  // tick when the low prescaler_select bits of the free counter are all high
  // a select of zero therefore ticks on every clock
  always_comb begin
    prescale_mask = 10'h000;
    for (int i = 0; i < 10; i++) begin
      if (4'(i) < prescaler_select) begin
        prescale_mask[i] = 1'b1;
      end
    end
  end
  assign prescale_tick = (prescale_cnt & prescale_mask) == prescale_mask;

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      // the counter wraps after active_period_value ticks
      assign period_end[g] = prescale_tick && counter[g] >= active_period_value[g] - 16'h0001;

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          counter[g] <= 16'h0000;
        end else if (period_end[g]) begin
          counter[g] <= 16'h0000;
        end else if (prescale_tick) begin
          counter[g] <= counter[g] + 16'h0001;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          period_update_value[g] <= `PWMTB_PERIOD_RESET;
          update_pending[g]      <= 1'b0;
        end else if (wr && period_index(wb_adr_i) == 3'(g)
                     && prot_clear(sw_protect_group_three, hwp_s2[1])) begin
          // a write on the period end edge stays pending for the next period
          period_update_value[g] <= wdata[`PWMTB_PERIOD_WIDTH-1:0];
          update_pending[g]      <= 1'b1;
        end else if (period_end[g]) begin
          update_pending[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          active_period_value[g] <= `PWMTB_PERIOD_RESET;
        // copied only at period end so the running period is never cut short
        end else if (period_end[g] && update_pending[g]) begin
          active_period_value[g] <= period_update_value[g];
        end
      end
    end

    for (g = 0; g < 2; g++) begin : g_trig
      pwmtb_trig_if tif ();
      assign tif.raw_trigger   = trig_s2[g];
      assign tif.source_select = trigger_source_select[g];
      assign tif.filter_enable = trigger_filter_enable[g];
      assign tif.blank_enables = blank_en[g];
      assign tif.blank_delay   = blanking_delay[g];
      assign tif.high_out      = high_side_output[g];
      assign tif.low_out       = low_side_output[g];
      assign tif.comparator    = comparator_out;
      assign trig_evt[g]       = tif.trigger_event;
      // channel index g+1 carries the trigger path
      pwmtb_trig_chan u_chan (
        .clk   (clk),
        .rst_n (rst_n),
        .tif   (tif)
      );
    end
  endgenerate

  // simple left-aligned outputs for channels 1 and 2, half period duty
  // the low side is the plain complement of the high side, with no dead time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_side_output <= 2'h0;
      low_side_output  <= 2'h0;
      trigger_event    <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        high_side_output[i] <= counter[i+1] < (active_period_value[i+1] >> 1);
        low_side_output[i]  <= !(counter[i+1] < (active_period_value[i+1] >> 1));
      end
      trigger_event <= trig_evt;
    end
  end

  // read mux; write-only registers read as zero
  // the hardware protection bits read back as their synchronised level
  always_comb begin
    next_dat = 32'h00000000;
    case (wb_adr_i)
      `PWMTB_IRQ_MASK_OFF:   next_dat = irq_mask;
      `PWMTB_IRQ_STATUS_OFF: next_dat = irq_status;
      `PWMTB_PROTECT_OFF:    next_dat = {20'h00000, hwp_s2[1], 1'b0, hwp_s2[0], 5'h00,
                                         sw_protect_group_three, 1'b0, sw_protect_group_one,
                                         1'b0};
      `PWMTB_PRESCALE_OFF:   next_dat = {28'h0000000, prescaler_select};
      default: begin
        for (int i = 0; i < CH; i++) begin
          if (is_active_period(wb_adr_i, i)) begin
            next_dat = {16'h0000, active_period_value[i]};
          end
        end
      end
    endcase
  end

  // read data is taken on the request edge and stands until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd) begin
      wb_dat_o <= next_dat;
    end
  end
endmodule

// >>> bench/ptbp_sva.sv
// checker for pwmtb_top: bus handshake, trigger pulses and interrupt line
// assumes it is bound to pwmtb_top and sees only its ports
`timescale 1ns/100ps
module ptbp_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [1:0]  ext_trigger_input,
  input wire logic        comparator_out,
  input wire logic [3:0]  counter_event,
  input wire logic [3:0]  fault_event,
  input wire logic [1:0]  trigger_event,
  input wire logic [1:0]  high_side_output,
  input wire logic [1:0]  low_side_output,
  input wire logic        irq
);
  int unsigned trig_age;
  int unsigned evt_age;
  int unsigned wr_age;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // cycles since a source of channel 1 was last high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) trig_age <= 31;
    else if (ext_trigger_input[0] || comparator_out) trig_age <= 0;
    else if (trig_age < 31) trig_age <= trig_age + 1;
  end
  // cycles since anything that may raise the interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) evt_age <= 31;
    else if ((|counter_event) || (|fault_event) || wb_ack_o) evt_age <= 0;
    else if (evt_age < 31) evt_age <= evt_age + 1;
  end
  // cycles since the last acknowledged write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wr_age <= 31;
    else if (wb_ack_o && wb_we_i) wr_age <= 0;
    else if (wr_age < 31) wr_age <= wr_age + 1;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");
  a_trig_pulse: assert property ((|trigger_event) |=>
                                 (trigger_event & $past(trigger_event)) == 2'h0)
    else $error("trigger event longer than one cycle");
  a_sides_opposite: assert property ($past(rst_n) |-> low_side_output == ~high_side_output)
    else $error("low side output is not the complement of the high side");
  a_trig_cause: assert property (trigger_event[0] |-> trig_age <= 10)
    else $error("trigger event with no source activity");
  a_irq_rise: assert property ($rose(irq) |-> evt_age <= 3)
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> wr_age <= 3)
    else $error("interrupt fell without a write");
  c_read: cover property (wb_ack_o && !wb_we_i);
  c_trig: cover property (trigger_event[0]);
  c_irq_on: cover property ($rose(irq));
  c_irq_off: cover property ($fell(irq));
endmodule
bind pwmtb_top ptbp_sva u_sva (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .ext_trigger_input(ext_trigger_input), .comparator_out(comparator_out),
  .counter_event(counter_event), .fault_event(fault_event),
  .trigger_event(trigger_event), .irq(irq), .high_side_output(high_side_output),
  .low_side_output(low_side_output));

// >>> bench/pwm_trigger_blanking_period_bench.sv
// self-checking bench for pwmtb_top: wishbone register tasks and trigger pulses
// assumes the design files under hdl/ are compiled first
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module pwm_trigger_blanking_period_bench;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [11:0] adr = 0;
  logic [31:0] dat = 0;
  logic [1:0]  ext = 0;
  logic        cmp_o = 0;
  logic        hw1 = 0;
  logic        hw3 = 0;
  logic [3:0]  cev = 0;
  logic [3:0]  fev = 0;
  logic [31:0] rdat;
  logic        ack;
  logic [1:0]  hso;
  logic [1:0]  lso;
  logic [1:0]  tev;
  logic        irq;
  logic        hso_q = 0;
  logic [31:0] rd;
  int          hits;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  pwmtb_top DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_trigger_input(ext), .comparator_out(cmp_o), .hw_protect_group_one(hw1),
    .hw_protect_group_three(hw3), .counter_event(cev), .fault_event(fev),
    .high_side_output(hso), .low_side_output(lso), .trigger_event(tev), .irq(irq));
  always #10 clk = ~clk;
  always @(posedge clk) hso_q <= hso[0];
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string n);
    wb_xfer(0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  task automatic pulse(input logic [3:0] c, input logic [3:0] f);
    @(posedge clk);
    cev <= c;
    fev <= f;
    @(posedge clk);
    cev <= 4'h0;
    fev <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  // pin or comparator high for wid cycles, counting events on channel ch over wid+14 cycles from the rise
  task automatic trig_try(input int ch, input logic cmp, input int wid, input int e,
                          input string n);
    int k;
    hits = 0;
    @(posedge clk);
    if (cmp) cmp_o <= 1;
    else ext[ch] <= 1;
    for (k = 0; k < wid + 14; k++) begin
      @(posedge clk);
      if (k == wid - 1) begin
        cmp_o <= 0;
        ext <= 2'h0;
      end
      if (tev[ch] === 1'b1) hits++;
    end
    `CHK(n, e, hits)
  endtask
  task automatic period_of(output int n);
    n = 0;
    do @(posedge clk); while (!(hso[0] === 1'b1 && hso_q === 1'b0));
    do begin
      @(posedge clk);
      n++;
    end while (!(hso[0] === 1'b1 && hso_q === 1'b0) && n < 5000);
  endtask
  initial begin
    int k;
    int n;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rchk(12'h22C, 32'h0000FFFF, "active_rst");
    rchk(12'h100, 32'h0, "unmapped");
    wb_xfer(1, 12'h230, 32'h00AB0012);
    wb_xfer(1, 12'h250, 32'h00CD0012);
    rchk(12'h22C, 32'h0000FFFF, "buffered");
    wb_xfer(1, 12'h010, 32'h000F000F);
    rchk(12'h018, 32'h000F000F, "mask");
    pulse(4'h4, 4'h0);
    `CHK("irq_on", 1'b1, irq)
    rchk(12'h020, 32'h00000004, "status");
    wb_xfer(1, 12'h0E4, 32'h2);
    wb_xfer(1, 12'h014, 32'h00040004);
    rchk(12'h018, 32'h000F000F, "mask_sw");
    wb_xfer(1, 12'h0E4, 32'h0);
    hw1 <= 1;
    repeat (4) @(posedge clk);
    wb_xfer(1, 12'h014, 32'h00040004);
    hw1 <= 0;
    rchk(12'h018, 32'h000F000F, "mask_hw");
    repeat (4) @(posedge clk);
    wb_xfer(1, 12'h014, 32'h00040004);
    rchk(12'h018, 32'h000B000B, "mask_dis");
    `CHK("irq_off", 1'b0, irq)
    rchk(12'h020, 32'h00000004, "sticky");
    wb_xfer(1, 12'h020, 32'h00000004);
    rchk(12'h020, 32'h0, "w1c");
    pulse(4'h0, 4'h2);
    `CHK("irq_fault", 1'b1, irq)
    wb_xfer(1, 12'h014, 32'h00020000);
    rchk(12'h018, 32'h0009000B, "mask_fdis");
    `CHK("irq_fault_off", 1'b0, irq)
    k = 0;
    do begin
      wb_xfer(0, 12'h22C, 32'h0);
      k++;
    end while (rd !== 32'h00000012 && k < 30000);
    `CHK("active1", 32'h00000012, rd)
    rchk(12'h24C, 32'h00000012, "active2");
    for (k = 0; k < 2; k++) begin
      if (k == 0) wb_xfer(1, 12'h0E4, 32'h8);
      else hw3 <= 1;
      repeat (4) @(posedge clk);
      wb_xfer(1, 12'h230, 32'h00000020);
      wb_xfer(1, 12'h0E4, 32'h0);
      hw3 <= 0;
      repeat (100) @(posedge clk);
      rchk(12'h22C, 32'h00000012, "protect3");
    end
    period_of(n);
    `CHK("period_x1", 18, n)
    wb_xfer(1, 12'h028, 32'h1);
    repeat (40) @(posedge clk);
    period_of(n);
    `CHK("period_x2", 36, n)
    wb_xfer(1, 12'h028, 32'h0);
    wb_xfer(1, 12'h06C, 32'h0);
    trig_try(0, 0, 2, 1, "pin1");
    trig_try(1, 0, 2, 1, "pin2");
    wb_xfer(1, 12'h06C, 32'h1);
    trig_try(0, 0, 2, 0, "pin_unsel");
    trig_try(0, 1, 2, 1, "cmp1");
    wb_xfer(1, 12'h06C, 32'h2);
    trig_try(0, 0, 2, 0, "filt_short");
    trig_try(0, 0, 6, 1, "filt_long");
    wb_xfer(1, 12'h06C, 32'h0);
    for (k = 16; k < 20; k++) begin
      wb_xfer(1, 12'h070, (32'h1 << k) | 32'h0000007F);
      // let blanking started by the previous enable run out first
      repeat (150) @(posedge clk);
      trig_try(0, 0, 2, 0, "blanked");
    end
    wb_xfer(1, 12'h080, 32'h000F0000);
    trig_try(1, 0, 2, 1, "zero_delay");
    wb_xfer(1, 12'h070, 32'h0000007F);
    repeat (150) @(posedge clk);
    trig_try(0, 0, 2, 1, "unarmed");
    wrap_up();
  end
endmodule
